//--- hw/acc_pkg.sv
package acc_pkg;
    // Conversion and calibration lengths in system clock cycles.
    localparam int          CONV_CYCLES  = 20;
    localparam int          CAL_CYCLES   = 40;
    localparam logic [7:0]  CNT_ZERO     = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [4:0]  BIT_LAST     = 5'h0F;
    // Idle levels of the eleven pin inputs, so no false edge follows reset.
    localparam logic [10:0] PIN_IDLE     = 11'h4C0;

    // Main control states.
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_CONV = 2'b01,
        ACC_CAL  = 2'b10
    } acc_state_t;
endpackage

//--- hw/acc_buf2.sv
`timescale 1ns/1ns
// Two-entry buffer between the conversion engine and the serial shifter.
module acc_buf2 (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] in_data,
    input  wire logic        in_valid,
    output logic             in_ready,
    output logic [15:0]      out_data,
    output logic             out_valid,
    input  wire logic        out_ready
);
    typedef struct packed {
        logic [1:0][15:0] mem;
        logic             wp;
        logic             rp;
        logic [1:0]       cnt;
    } acc_buf_t;

    acc_buf_t st_r;
    acc_buf_t st_nxt;

    // Pointer and count update for push and pop.
    always_comb begin
        st_nxt = st_r;
        if (in_valid && in_ready) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = ~st_r.wp;
        end
        if (out_valid && out_ready) begin
            st_nxt.rp = ~st_r.rp;
        end
        st_nxt.cnt = st_r.cnt + 2'((in_valid && in_ready) ? 1 : 0)
                   - 2'((out_valid && out_ready) ? 1 : 0);
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign in_ready  = (st_r.cnt != 2'h2);
    assign out_valid = (st_r.cnt != 2'h0);
    assign out_data  = st_r.mem[st_r.rp];
endmodule // acc_buf2

//--- hw/acc_ctrl.sv
`timescale 1ns/1ns
// Contract
// - Output bus enabled only when select and read low.
// - Select high gates the serial clock.
// - Reset high aborts conversion, discards result.
// - Reset falling edge starts calibration, busy high.
// - Power-down finishes conversion, then blocks starts.
// - Start falling edge holds sample, begins conversion.
// - Both reference power-downs low enable reference.
// - Fast serial clock makes data valid one edge later; here each active edge, select low and external clock, presents the next bit; no fast-clock mode.
// - Busy high from start until result latched.
// - Output updates on rising or falling clock per polarity.
module acc_ctrl (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        convert_start_n,
    input  wire logic        adc_reset,
    input  wire logic        powerdown_in,
    input  wire logic        chip_select_n,
    input  wire logic        read_n,
    input  wire logic        ref_powerdown,
    input  wire logic        refbuf_powerdown,
    input  wire logic        serial_clock,
    input  wire logic        serial_clock_polarity,
    input  wire logic        clock_source_select,
    input  wire logic        serial_mode,
    input  wire logic        compare_bit,
    output logic             busy,
    output logic             track_hold,
    output logic [15:0]      par_data,
    output logic             par_data_oe,
    output logic             serial_out,
    output logic             serial_out_oe,
    output logic             ref_enable,
    output logic             refbuf_enable,
    output logic             adc_powered
);
    // Controller state, including synchroniser stages for the eleven pin inputs.
    typedef struct packed {
        logic [10:0] s1;
        logic [10:0] s2;
        logic        cnv_d;
        logic        rst_d;
        logic        sck_d;
        acc_pkg::acc_state_t state;
        logic [7:0]  cnt;
        logic [15:0] sar;
        logic        push;
        logic        busy;
        logic        hold;
        logic [15:0] shreg;
        logic [4:0]  bitn;
        logic        loaded;
        logic        sdo;
        logic        sdo_oe;
        logic        par_oe;
        logic [15:0] pdata;
        logic        ref_en;
        logic        buf_en;
        logic        pwr;
    } acc_st_t;

    acc_st_t st_r;
    acc_st_t st_nxt;

    logic [15:0] b_data;
    logic        b_valid;
    logic        b_ready;
    logic        b_in_ready;
    logic [10:0] pins;
    logic        cnv_s, rst_s, pd_s, cs_n_s, rd_n_s, pdr_s, pdb_s;
    logic        sck_s, inv_s, ext_s, ser_s;
    logic        sck_act;

    assign pins = {convert_start_n, adc_reset, powerdown_in, chip_select_n,
                   read_n, ref_powerdown, refbuf_powerdown, serial_clock,
                   serial_clock_polarity, clock_source_select, serial_mode};
    assign {cnv_s, rst_s, pd_s, cs_n_s, rd_n_s, pdr_s, pdb_s,
            sck_s, inv_s, ext_s, ser_s} = st_r.s2;

    // Active serial edge: rising for normal polarity, falling inverted.
    assign sck_act = inv_s ? (st_r.sck_d && !sck_s)
                           : (!st_r.sck_d && sck_s);

    acc_buf2 u_buf (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .in_data   (st_r.sar),
        .in_valid  (st_r.push),
        .in_ready  (b_in_ready),
        .out_data  (b_data),
        .out_valid (b_valid),
        .out_ready (b_ready)
    );

    // Serial shifter takes a word when idle or drained; parallel always.
    assign b_ready = !st_r.loaded || !ser_s;

    // Next-state logic for the whole controller.
    always_comb begin
        st_nxt       = st_r;
        st_nxt.s1    = pins;
        st_nxt.s2    = st_r.s1;
        st_nxt.cnv_d = cnv_s;
        st_nxt.rst_d = rst_s;
        st_nxt.sck_d = sck_s;
        st_nxt.push  = 1'b0;
        case (st_r.state)
            acc_pkg::ACC_IDLE: begin
                st_nxt.busy = 1'b0;
                st_nxt.hold = 1'b0;
                // Start blocked while powered down or stalled by buffer.
                if (st_r.cnv_d && !cnv_s && !pd_s && !rst_s
                    && b_in_ready) begin
                    st_nxt.state = acc_pkg::ACC_CONV;
                    st_nxt.hold  = 1'b1;
                    st_nxt.busy  = 1'b1;
                    st_nxt.cnt   = 8'(acc_pkg::CONV_CYCLES);
                    st_nxt.sar   = acc_pkg::RESULT_RESET;
                end
            end
            acc_pkg::ACC_CONV: begin
                // Conversion keeps running under power-down.
                st_nxt.cnt = st_r.cnt - 8'h01;
                st_nxt.sar = {st_r.sar[14:0], compare_bit};
                if (st_r.cnt == 8'h01) begin
                    st_nxt.state = acc_pkg::ACC_IDLE;
                    st_nxt.push  = 1'b1;
                    st_nxt.busy  = 1'b0;
                    st_nxt.hold  = 1'b0;
                end
            end
            acc_pkg::ACC_CAL: begin
                st_nxt.cnt = st_r.cnt - 8'h01;
                if (st_r.cnt == 8'h01) begin
                    st_nxt.state = acc_pkg::ACC_IDLE;
                    st_nxt.busy  = 1'b0;
                end
            end
            default: begin
                st_nxt.state = acc_pkg::ACC_IDLE;
            end
        endcase
        // Reset pin aborts and discards; release begins calibration.
        if (rst_s) begin
            st_nxt.state = acc_pkg::ACC_IDLE;
            st_nxt.busy  = 1'b0;
            st_nxt.hold  = 1'b0;
            st_nxt.push  = 1'b0;
        end else if (st_r.rst_d) begin
            st_nxt.state = acc_pkg::ACC_CAL;
            st_nxt.busy  = 1'b1;
            st_nxt.cnt   = 8'(acc_pkg::CAL_CYCLES);
        end
        // Serial shifter: load from buffer, shift on gated active edge.
        if (b_ready && b_valid) begin
            st_nxt.shreg  = b_data;
            st_nxt.pdata  = b_data;
            st_nxt.loaded = 1'b1;
            st_nxt.bitn   = 5'h00;
            st_nxt.sdo    = b_data[15];
        end else if (st_r.loaded && ser_s && ext_s && !cs_n_s
                     && sck_act) begin
            st_nxt.shreg = {st_r.shreg[14:0], 1'b0};
            st_nxt.sdo   = st_r.shreg[14];
            st_nxt.bitn  = st_r.bitn + 5'h01;
            if (st_r.bitn == acc_pkg::BIT_LAST) begin
                st_nxt.loaded = 1'b0;
            end
        end
        // Output drivers enabled only for select and read both low.
        st_nxt.par_oe = !cs_n_s && !rd_n_s && !ser_s;
        st_nxt.sdo_oe = !cs_n_s && !rd_n_s && ser_s;
        // Reference and buffer enables from the power-down pins.
        st_nxt.ref_en = !pdr_s;
        st_nxt.buf_en = !pdb_s;
        st_nxt.pwr    = !pd_s || (st_r.state == acc_pkg::ACC_CONV);
    end

    // State register.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r       <= '0;
            st_r.s1    <= acc_pkg::PIN_IDLE;
            st_r.s2    <= acc_pkg::PIN_IDLE;
            st_r.cnv_d <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy          = st_r.busy;
    assign track_hold    = st_r.hold;
    assign par_data      = st_r.pdata;
    assign par_data_oe   = st_r.par_oe;
    assign serial_out    = st_r.sdo;
    assign serial_out_oe = st_r.sdo_oe;
    assign ref_enable    = st_r.ref_en;
    assign refbuf_enable = st_r.buf_en;
    assign adc_powered   = st_r.pwr;

    // Busy must fall within 21 cycles, one past the conversion length, after a start.
    property p_busy_conv;
        @(posedge sys_clk) disable iff (sys_rst || rst_s)
        $rose(track_hold) |-> busy ##[1:21] !busy;
    endproperty
    a_busy_conv: assert property (p_busy_conv)
        else $error("Busy did not fall after conversion.");

    property p_oe_gate;
        @(posedge sys_clk) disable iff (sys_rst)
        (par_data_oe || serial_out_oe) |-> $past(!cs_n_s && !rd_n_s);
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("Output enabled without select and read.");

    property p_abort;
        @(posedge sys_clk) disable iff (sys_rst)
        $past(rst_s) && rst_s |-> !busy && !st_r.push;
    endproperty
    a_abort: assert property (p_abort)
        else $error("Conversion not aborted in reset.");

    property p_cal;
        @(posedge sys_clk) disable iff (sys_rst)
        !rst_s && st_r.rst_d |=> busy [*8];
    endproperty
    a_cal: assert property (p_cal)
        else $error("Calibration busy missing.");

    property p_pd;
        @(posedge sys_clk) disable iff (sys_rst)
        (st_r.state == acc_pkg::ACC_IDLE) && pd_s |=>
            st_r.state != acc_pkg::ACC_CONV;
    endproperty
    a_pd: assert property (p_pd)
        else $error("Conversion started in power-down.");

    property p_start;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(track_hold) |-> $past(st_r.cnv_d && !cnv_s);
    endproperty
    a_start: assert property (p_start)
        else $error("Hold without start edge.");

    property p_ref;
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> ref_enable == !$past(pdr_s);
    endproperty
    a_ref: assert property (p_ref)
        else $error("Reference enable mismatch.");

    property p_gate;
        @(posedge sys_clk) disable iff (sys_rst)
        st_r.loaded && cs_n_s && !(b_ready && b_valid)
            |=> $stable(st_r.bitn);
    endproperty
    a_gate: assert property (p_gate)
        else $error("Shift while select high.");
endmodule // acc_ctrl

//--- testbench/acc_host_model.sv
`timescale 1ns/1ns
// Host side of the serial link: makes slave clock edges, samples the data.
module acc_host_model (
    input  wire logic sys_clk,
    input  wire logic serial_out,
    input  wire logic pol,
    output logic      serial_clock
);
    // The clock stands at its idle level outside frames.
    initial serial_clock = 1'b0;

    // Each phase lasts four system cycles, twice the two-stage synchroniser delay.
    task automatic edges(input int k);
        repeat (k) begin
            serial_clock = ~pol;
            repeat (4) @(negedge sys_clk);
            serial_clock = pol;
            repeat (4) @(negedge sys_clk);
        end
    endtask

    // Data is taken in the idle phase, before each active edge.
    task automatic read_word(output logic [15:0] w);
        serial_clock = pol;
        repeat (4) @(negedge sys_clk);
        for (int i = 15; i >= 0; i--) begin
            w[i] = serial_out;
            edges(1);
        end
    endtask
endmodule // acc_host_model

//--- testbench/acc_ctrl_test.sv
`timescale 1ns/1ns
// Self-checking bench for the converter control pins.
module acc_ctrl_test;
    logic        sys_clk, sys_rst, convert_start_n, adc_reset;
    logic        powerdown_in, chip_select_n, read_n, ref_powerdown;
    logic        refbuf_powerdown, serial_clock, serial_clock_polarity;
    logic        clock_source_select, serial_mode, compare_bit;
    logic        busy, track_hold, par_data_oe, serial_out, serial_out_oe;
    logic        ref_enable, refbuf_enable, adc_powered;
    logic [15:0] par_data, w;
    int          fails = 0;
    int          comparisons = 0;
    int          n;

    acc_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .convert_start_n(convert_start_n), .adc_reset(adc_reset),
        .powerdown_in(powerdown_in), .chip_select_n(chip_select_n),
        .read_n(read_n), .ref_powerdown(ref_powerdown),
        .refbuf_powerdown(refbuf_powerdown), .serial_clock(serial_clock),
        .serial_clock_polarity(serial_clock_polarity),
        .clock_source_select(clock_source_select),
        .serial_mode(serial_mode), .compare_bit(compare_bit), .busy(busy),
        .track_hold(track_hold), .par_data(par_data),
        .par_data_oe(par_data_oe), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .ref_enable(ref_enable),
        .refbuf_enable(refbuf_enable), .adc_powered(adc_powered));

    acc_host_model host (.sys_clk(sys_clk), .serial_out(serial_out),
        .pol(serial_clock_polarity), .serial_clock(serial_clock));

    // System clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits a bounded time for busy, then counts its high cycles.
    task automatic busy_len(input logic th, output int len);
        int g;
        g = 0;
        len = 0;
        while (busy !== 1'b1 && g < 10) begin
            tick(1);
            g++;
        end
        if (th && g < 10) check(16'(track_hold), 16'h0001);
        while (busy === 1'b1 && len < 200) begin
            tick(1);
            len++;
        end
    endtask

    task automatic convert(input logic b, output int len);
        compare_bit = b;
        convert_start_n = 1'b0;
        tick(3);
        convert_start_n = 1'b1;
        busy_len(1'b1, len);
    endtask

    task automatic t_cal;
        adc_reset = 1'b1;
        tick(6);
        check(16'(busy), 16'h0000);
        adc_reset = 1'b0;
        busy_len(1'b0, n);
        check(16'(n), 16'(acc_pkg::CAL_CYCLES));
        $display("calibration test done");
    endtask

    // Two words queue up while the host stalls with select high.
    task automatic t_serial;
        serial_mode = 1'b1;
        clock_source_select = 1'b1;
        read_n = 1'b0;
        convert(1'b1, n);
        check(16'(n), 16'(acc_pkg::CONV_CYCLES));
        convert(1'b0, n);
        host.edges(4);
        check(16'(serial_out_oe), 16'h0000);
        chip_select_n = 1'b0;
        tick(4);
        check(16'(serial_out_oe), 16'h0001);
        host.read_word(w);
        check(w, 16'hFFFF);
        serial_clock_polarity = 1'b1;
        tick(4);
        host.read_word(w);
        check(w, 16'h0000);
        chip_select_n = 1'b1;
        $display("serial test done");
    endtask

    task automatic t_ref;
        ref_powerdown = 1'b1;
        refbuf_powerdown = 1'b1;
        tick(4);
        check(16'({ref_enable, refbuf_enable}), 16'h0000);
        ref_powerdown = 1'b0;
        refbuf_powerdown = 1'b0;
        tick(4);
        check(16'({ref_enable, refbuf_enable}), 16'h0003);
        $display("reference test done");
    endtask

    task automatic t_par;
        serial_mode = 1'b0;
        chip_select_n = 1'b0;
        read_n = 1'b1;
        convert(1'b1, n);
        tick(4);
        check(16'(par_data_oe), 16'h0000);
        read_n = 1'b0;
        tick(4);
        check(16'(par_data_oe), 16'h0001);
        check(par_data, 16'hFFFF);
        chip_select_n = 1'b1;
        tick(4);
        check(16'(par_data_oe), 16'h0000);
        $display("parallel test done");
    endtask

    task automatic t_abort;
        compare_bit = 1'b0;
        convert_start_n = 1'b0;
        tick(12);
        convert_start_n = 1'b1;
        adc_reset = 1'b1;
        tick(4);
        check(16'(busy), 16'h0000);
        adc_reset = 1'b0;
        busy_len(1'b0, n);
        check(16'(n), 16'(acc_pkg::CAL_CYCLES));
        $display("abort test done");
    endtask

    // Power-down in mid-conversion lets it finish, then blocks starts.
    task automatic t_pd;
        convert_start_n = 1'b0;
        tick(6);
        powerdown_in = 1'b1;
        convert_start_n = 1'b1;
        busy_len(1'b0, n);
        check(16'(n > 0 && n <= acc_pkg::CONV_CYCLES), 16'h0001);
        convert(1'b1, n);
        tick(30);
        check(16'({busy, adc_powered}), 16'h0000);
        powerdown_in = 1'b0;
        tick(4);
        check(16'(adc_powered), 16'h0001);
        convert(1'b1, n);
        check(16'(n), 16'(acc_pkg::CONV_CYCLES));
        $display("power-down test done");
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about six hundred cycles.
    initial begin
        tick(6000);
        fails++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        {sys_rst, convert_start_n, chip_select_n, read_n} = 4'hF;
        {adc_reset, powerdown_in, ref_powerdown, refbuf_powerdown} = 4'h0;
        {serial_clock_polarity, clock_source_select} = 2'h0;
        {serial_mode, compare_bit} = 2'h0;
        tick(4);
        sys_rst = 1'b0;
        tick(3);
        t_cal();
        t_serial();
        t_ref();
        t_par();
        t_abort();
        t_pd();
        wrap_up();
    end
endmodule // acc_ctrl_test
